// ### verilog/krc_consts.vh
// register map, field positions and timing counts for the keyed reset block
// assumes an internal register port with 10-bit byte addresses and 8-bit data
`ifndef KRC_CONSTS_VH
`define KRC_CONSTS_VH

// ****************************************
// register offsets
// ****************************************
`define KRC_ADDR_SOFT       10'h280
`define KRC_ADDR_HARD       10'h281
`define KRC_ADDR_FULL       10'h282
`define KRC_ADDR_SCNT       10'h283
`define KRC_ADDR_FUSE       10'h339
`define KRC_ADDR_REV_HI     10'h3c1
`define KRC_ADDR_REV_LO     10'h3d0

// ****************************************
// fields and reset values
// ****************************************
`define KRC_SCNT_CLR_BIT    7
`define KRC_SCNT_MAX        7'h7f
`define KRC_SCNT_ONE        7'h01
`define KRC_CMD_RST         8'h00
`define KRC_FUSE_CRC_BIT    4
`define KRC_FUSE_BUSY_BIT   0
`define KRC_ZERO8           8'h00

// ****************************************
// timing for a 10 MHz mclk, in ns and in mclk cycles
// ****************************************
`define KRC_CLK_NS          100
`define KRC_PULSE_NS        1000
`define KRC_PULSE_CYC       16'h000a
`define KRC_CNT_W           16

`endif

// ### verilog/krc_key_match.v
// key-derived trigger value decoder
// assumes key is the current unlock key, stable while compared
`timescale 1ns/1ps
`default_nettype none

module krc_key_match
(
   // key and written data
   input  wire [7:0] key,
   input  wire [7:0] wdata,
   // match flags
   output wire       soft_hit,
   output wire       hard_hit,
   output wire       full_hit
);

   wire [7:0] key_rev;

   // ****************************************
   // bit reversal of the key
   // ****************************************
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1)
      begin : g_rev
         assign key_rev[i] = key[7-i];
      end
   endgenerate

   assign soft_hit = (wdata == ~key);
   assign hard_hit = (wdata == {key[3:0], key[7:4]});
   assign full_hit = (wdata == key_rev);

endmodule // krc_key_match

`default_nettype wire

// ### verilog/krc_pulse_timer.v
// fixed-length countdown used for the reset output pulse
// assumes start is a one-cycle pulse; start while busy is ignored
`timescale 1ns/1ps
`default_nettype none
`include "krc_consts.vh"

module krc_pulse_timer
(
   // clock and reset
   input  wire                  mclk,
   input  wire                  reset_n,
   // control
   input  wire                  start,
   input  wire [`KRC_CNT_W-1:0] length,
   // status
   output wire                  busy,
   output wire                  done
);

   reg [`KRC_CNT_W-1:0] cnt_q;
   reg                  done_q;

   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_q  <= {`KRC_CNT_W{1'b0}};
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         if (cnt_q != {`KRC_CNT_W{1'b0}})
         begin
            cnt_q <= cnt_q - {{(`KRC_CNT_W-1){1'b0}}, 1'b1};
            if (cnt_q == {{(`KRC_CNT_W-1){1'b0}}, 1'b1})
               done_q <= 1'b1;
         end
         else if (start)
            cnt_q <= length;
      end
   end

   assign busy = (cnt_q != {`KRC_CNT_W{1'b0}});
   assign done = done_q;

endmodule // krc_pulse_timer

`default_nettype wire

// ### verilog/krc_reset_ctrl.v
// keyed reset commands, startup counter and fuse status registers
// assumes a synchronous internal register port from the serial interface;
// the rail sequencer, fuse controller and key register sit outside
`timescale 1ns/1ps
`default_nettype none
`include "krc_consts.vh"

// Behaviour
// - soft command equal to inverted key pulses system_reset_out low; others ignored
// - soft reset pulse uses the first fault-handling case timing
// - hard command equal to nibble-swapped key sequences rails down and reset low
// - hard reset uses the second fault-handling case timing
// - full-restart command equal to bit-reversed key starts shutdown, reset, restart
// - full restart uses engine-off-only shutdown; always-on regulator stays enabled
// - each regulator finishes its discharge interval before restart
// - full restart restores registers, reloads fuses and reruns self test
// - power-up after full restart uses wake-controlled enable timing
// - 7-bit startup counter counts reset-output rising edges at startup
// - startup counter saturates at maximum, never wraps
// - writing one to bit 7 clears the counter; zero does nothing
// - only one clear per power cycle or full restart
// - fuse status bit 4 shows fuse CRC failure
// - fuse status bit 0 shows fuse controller busy
// - fuse shadow writes are blocked while fuse controller busy
// - 16-bit OTP revision readable as high and low bytes
module krc_reset_ctrl
(
   // clock and reset
   input  wire        mclk,
   input  wire        reset_n,
   // register port
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire [9:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   output reg  [7:0]  reg_rdata_q,
   // unlock key
   input  wire [7:0]  unlock_key,
   // fuse controller
   input  wire        fuse_busy,
   input  wire        fuse_crc_fail,
   input  wire [15:0] otp_revision,
   input  wire        shadow_wr_req,
   output reg         shadow_wr_en_q,
   // sequencer handshakes
   input  wire        seq_down_done,
   input  wire        discharge_done,
   input  wire        reload_done,
   input  wire        wake_up_done,
   // reset output and sequencer requests
   output reg         system_reset_out_q,
   output reg         rails_down_req_q,
   output reg         engine_off_only_shutdown_q,
   output reg         always_on_regulator_en_q,
   output reg         reload_req_q,
   output reg         wake_up_req_q
);

   localparam [5:0] ST_IDLE   = 6'b00_0001;
   localparam [5:0] ST_SOFT   = 6'b00_0010;
   localparam [5:0] ST_HARD   = 6'b00_0100;
   localparam [5:0] ST_FDOWN  = 6'b00_1000;
   localparam [5:0] ST_RELOAD = 6'b01_0000;
   localparam [5:0] ST_WAKE   = 6'b10_0000;

   reg  [5:0] state_q;
   reg  [5:0] state_d;
   reg  [7:0] soft_cmd_q;
   reg  [7:0] hard_cmd_q;
   reg  [7:0] full_cmd_q;
   reg  [6:0] startup_counter_q;
   reg        clear_used_q;
   reg        rst_prev_q;
   reg        disch_seen_q;
   reg        soft_init_q;
   wire       soft_hit;
   wire       hard_hit;
   wire       full_hit;
   wire       tmr_busy;
   wire       tmr_done;
   wire       wr_soft;
   wire       wr_hard;
   wire       wr_full;
   wire       wr_scnt;
   wire       idle;
   wire       rst_rise;
   wire       full_go;

   // ****************************************
   // key decode and pulse timer
   // ****************************************
   krc_key_match u_match
   (
      .key      (unlock_key),
      .wdata    (reg_wdata),
      .soft_hit (soft_hit),
      .hard_hit (hard_hit),
      .full_hit (full_hit)
   );

   assign idle    = (state_q == ST_IDLE);
   assign wr_soft = reg_wr && (reg_addr == `KRC_ADDR_SOFT);
   assign wr_hard = reg_wr && (reg_addr == `KRC_ADDR_HARD);
   assign wr_full = reg_wr && (reg_addr == `KRC_ADDR_FULL);
   assign wr_scnt = reg_wr && (reg_addr == `KRC_ADDR_SCNT);
   assign full_go = idle && wr_full && full_hit;

   krc_pulse_timer u_timer
   (
      .mclk    (mclk),
      .reset_n (reset_n),
      .start   (idle && wr_soft && soft_hit),
      .length  (`KRC_PULSE_CYC),
      .busy    (tmr_busy),
      .done    (tmr_done)
   );

   // ****************************************
   // reset action sequencer
   // ****************************************
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
         begin
            if (wr_soft && soft_hit)
               state_d = ST_SOFT;
            else if (wr_hard && hard_hit)
               state_d = ST_HARD;
            else if (wr_full && full_hit)
               state_d = ST_FDOWN;
         end
         ST_SOFT:
            if (tmr_done)
               state_d = ST_IDLE;
         ST_HARD:
            if (seq_down_done)
               state_d = ST_IDLE;
         ST_FDOWN:
            if (seq_down_done && (discharge_done || disch_seen_q))
               state_d = ST_RELOAD;
         ST_RELOAD:
            if (reload_done)
               state_d = ST_WAKE;
         ST_WAKE:
            if (wake_up_done)
               state_d = ST_IDLE;
         default:
            state_d = ST_IDLE;
      endcase
   end

   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q                    <= ST_IDLE;
         disch_seen_q               <= 1'b0;
         system_reset_out_q         <= 1'b0;
         rails_down_req_q           <= 1'b0;
         engine_off_only_shutdown_q <= 1'b0;
         always_on_regulator_en_q   <= 1'b1;
         reload_req_q               <= 1'b0;
         wake_up_req_q              <= 1'b0;
         soft_init_q                <= 1'b0;
      end
      else
      begin
         state_q                    <= state_d;
         soft_init_q                <= 1'b1;
         if (state_q == ST_FDOWN && discharge_done)
            disch_seen_q <= 1'b1;
         else if (state_q != ST_FDOWN)
            disch_seen_q <= 1'b0;
         system_reset_out_q         <= soft_init_q && (state_d == ST_IDLE);
         rails_down_req_q           <= (state_d == ST_HARD) || (state_d == ST_FDOWN);
         engine_off_only_shutdown_q <= (state_d == ST_FDOWN);
         always_on_regulator_en_q   <= 1'b1;
         reload_req_q               <= (state_d == ST_RELOAD);
         wake_up_req_q              <= (state_d == ST_WAKE);
      end
   end

   // ****************************************
   // command registers and startup counter
   // ****************************************
   assign rst_rise = system_reset_out_q && !rst_prev_q;

   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         soft_cmd_q        <= `KRC_CMD_RST;
         hard_cmd_q        <= `KRC_CMD_RST;
         full_cmd_q        <= `KRC_CMD_RST;
         startup_counter_q <= 7'h00;
         clear_used_q      <= 1'b0;
         rst_prev_q        <= 1'b0;
      end
      else
      begin
         rst_prev_q <= system_reset_out_q;
         if (full_go)
         begin
            soft_cmd_q   <= `KRC_CMD_RST;
            hard_cmd_q   <= `KRC_CMD_RST;
            full_cmd_q   <= `KRC_CMD_RST;
            clear_used_q <= 1'b0;
         end
         else
         begin
            if (wr_soft)
               soft_cmd_q <= reg_wdata;
            if (wr_hard)
               hard_cmd_q <= reg_wdata;
            if (wr_full)
               full_cmd_q <= reg_wdata;
            if (wr_scnt && reg_wdata[`KRC_SCNT_CLR_BIT] && !clear_used_q)
               clear_used_q <= 1'b1;
         end
         if (wr_scnt && reg_wdata[`KRC_SCNT_CLR_BIT] && !clear_used_q && !full_go)
            startup_counter_q <= rst_rise ? `KRC_SCNT_ONE : 7'h00;
         else if (rst_rise && startup_counter_q != `KRC_SCNT_MAX)
            startup_counter_q <= startup_counter_q + `KRC_SCNT_ONE;
      end
   end

   // ****************************************
   // fuse shadow write gate
   // ****************************************
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         shadow_wr_en_q <= 1'b0;
      else
         shadow_wr_en_q <= shadow_wr_req && !fuse_busy;
   end

   // ****************************************
   // read data
   // ****************************************
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         reg_rdata_q <= `KRC_ZERO8;
      else if (reg_rd)
      begin
         case (reg_addr)
            `KRC_ADDR_SOFT:   reg_rdata_q <= soft_cmd_q;
            `KRC_ADDR_HARD:   reg_rdata_q <= hard_cmd_q;
            `KRC_ADDR_FULL:   reg_rdata_q <= full_cmd_q;
            `KRC_ADDR_SCNT:   reg_rdata_q <= {1'b0, startup_counter_q};
            `KRC_ADDR_FUSE:   reg_rdata_q <= {3'b000, fuse_crc_fail, 3'b000, fuse_busy};
            `KRC_ADDR_REV_HI: reg_rdata_q <= otp_revision[15:8];
            `KRC_ADDR_REV_LO: reg_rdata_q <= otp_revision[7:0];
            default:          reg_rdata_q <= `KRC_ZERO8;
         endcase
      end
   end

endmodule // krc_reset_ctrl

`default_nettype wire

// ### dv/krc_reset_ctrl_properties.sv
// checker for the keyed reset block
// assumes one clock domain, mclk, with asynchronous reset_n
`timescale 1ns/1ps
`default_nettype none
module krc_reset_ctrl_properties (
   // clock and reset
   input wire logic        mclk,
   input wire logic        reset_n,
   // register port
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [9:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata_q,
   // key and fuse side
   input wire logic [7:0]  unlock_key,
   input wire logic        fuse_busy,
   input wire logic        fuse_crc_fail,
   input wire logic [15:0] otp_revision,
   input wire logic        shadow_wr_en_q,
   // reset output and requests
   input wire logic        system_reset_out_q,
   input wire logic        rails_down_req_q,
   input wire logic        engine_off_only_shutdown_q,
   input wire logic        always_on_regulator_en_q,
   input wire logic        reload_req_q,
   input wire logic        wake_up_req_q
);
   // ****
   // properties
   // ****
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   wire       busy = rails_down_req_q || reload_req_q || wake_up_req_q;
   wire       idle = system_reset_out_q && !busy;
   wire [7:0] rev  = {<<{unlock_key}};
   sequence s_cmd(a, v);
      reg_wr && reg_addr == a && reg_wdata == v && idle;
   endsequence
   AST_SOFT_PULSE: assert property (s_cmd(10'h280, ~unlock_key) |=>
      !system_reset_out_q [*8] ##[1:12] system_reset_out_q) else $error("soft pulse");
   AST_HARD_START: assert property (s_cmd(10'h281, {unlock_key[3:0], unlock_key[7:4]})
      |=> rails_down_req_q && !system_reset_out_q && !engine_off_only_shutdown_q)
      else $error("hard start");
   AST_FULL_START: assert property (s_cmd(10'h282, rev) |=>
      rails_down_req_q && engine_off_only_shutdown_q && !system_reset_out_q)
      else $error("full start");
   AST_HOLD_LOW: assert property (busy |-> !system_reset_out_q)
      else $error("reset high mid action");
   AST_ONE_CAUSE: assert property ($fell(system_reset_out_q) |-> $past(reg_wr))
      else $error("reset fell without write");
   AST_AON: assert property (always_on_regulator_en_q)
      else $error("always-on off");
   AST_SHADOW_BLOCK: assert property (fuse_busy ##1 fuse_busy |-> !shadow_wr_en_q)
      else $error("shadow write while busy");
   AST_FUSE_READ: assert property (reg_rd && reg_addr == 10'h339 |=>
      reg_rdata_q == {3'h0, $past(fuse_crc_fail), 3'h0, $past(fuse_busy)})
      else $error("fuse status");
   AST_REV_HIGH: assert property (reg_rd && reg_addr == 10'h3c1 |=>
      reg_rdata_q == $past(otp_revision[15:8])) else $error("revision high");
   AST_REV_LOW: assert property (reg_rd && reg_addr == 10'h3d0 |=>
      reg_rdata_q == $past(otp_revision[7:0])) else $error("revision low");
endmodule // krc_reset_ctrl_properties
bind krc_reset_ctrl krc_reset_ctrl_properties i_props (.mclk, .reset_n, .reg_wr, .reg_rd,
   .reg_addr, .reg_wdata, .reg_rdata_q, .unlock_key, .fuse_busy, .fuse_crc_fail,
   .otp_revision, .shadow_wr_en_q, .system_reset_out_q, .rails_down_req_q,
   .engine_off_only_shutdown_q, .always_on_regulator_en_q, .reload_req_q, .wake_up_req_q);
`default_nettype wire

// ### dv/krc_seq_model.sv
// rail sequencer stand-in answering shutdown, reload and wake requests
// assumes requests are levels held until the matching done is seen
`timescale 1ns/1ps
`default_nettype none
module krc_seq_model (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       reset_n,
   // requests and answer delay
   input  wire logic       rails_down_req_q,
   input  wire logic       reload_req_q,
   input  wire logic       wake_up_req_q,
   input  wire logic [7:0] dly,
   // answers
   output logic            seq_down_done,
   output logic            discharge_done,
   output logic            reload_done,
   output logic            wake_up_done
);
   // ****
   // delay counter, restarted on each new request
   // ****
   wire  [2:0] req = {rails_down_req_q, reload_req_q, wake_up_req_q};
   logic [2:0] req_q;
   logic [7:0] n_q;
   always @(posedge mclk or negedge reset_n)
      if (!reset_n)
         {req_q, n_q} <= 11'h000;
      else
         {req_q, n_q} <= {req, (req != req_q) ? 8'h00 : n_q + {7'h00, n_q != 8'hff}};
   // answer only once the count belongs to the request now standing
   wire        fresh = (req == req_q);
   assign discharge_done = fresh && rails_down_req_q && n_q >= (dly >> 1);
   assign seq_down_done  = fresh && rails_down_req_q && n_q >= dly;
   assign reload_done    = fresh && reload_req_q && n_q >= dly;
   assign wake_up_done   = fresh && wake_up_req_q && n_q >= dly;
endmodule // krc_seq_model
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the keyed reset block with a register model
// assumes the sequencer model answers requests; checker bound elsewhere
`timescale 1ns/1ps
`default_nettype none
`include "krc_consts.vh"
module testbench;
   // ****
   // signals, model and tasks
   // ****
   logic        mclk, reset_n, reg_wr, reg_rd, fuse_busy, fuse_crc_fail, shadow_wr_req;
   logic [9:0]  reg_addr;
   logic [7:0]  reg_wdata, unlock_key, dly;
   logic [15:0] otp_revision;
   wire  [7:0]  reg_rdata_q;
   wire         shadow_wr_en_q, seq_down_done, discharge_done, reload_done, wake_up_done;
   wire         system_reset_out_q, rails_down_req_q, engine_off_only_shutdown_q;
   wire         always_on_regulator_en_q, reload_req_q, wake_up_req_q;
   logic [31:0] seed;
   logic [7:0]  cmd [3];
   logic [9:0]  addrs [8] = '{10'h280, 10'h281, 10'h282, 10'h283, 10'h339, 10'h3c1,
                              10'h3d0, 10'h300};
   int          mismatches, checks, cnt, permit, lo;
   krc_reset_ctrl i_dut (.mclk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata_q, .unlock_key, .fuse_busy, .fuse_crc_fail, .otp_revision, .shadow_wr_req,
      .shadow_wr_en_q, .seq_down_done, .discharge_done, .reload_done, .wake_up_done,
      .system_reset_out_q, .rails_down_req_q, .engine_off_only_shutdown_q,
      .always_on_regulator_en_q, .reload_req_q, .wake_up_req_q);
   krc_seq_model i_seq (.mclk, .reset_n, .rails_down_req_q, .reload_req_q, .wake_up_req_q,
      .dly, .seq_down_done, .discharge_done, .reload_done, .wake_up_done);
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   function automatic logic [7:0] model(input logic [9:0] a);
      case (a)
         `KRC_ADDR_SOFT, `KRC_ADDR_HARD, `KRC_ADDR_FULL: return cmd[a - `KRC_ADDR_SOFT];
         `KRC_ADDR_SCNT: return 8'(cnt);
         `KRC_ADDR_FUSE: return {3'h0, fuse_crc_fail, 3'h0, fuse_busy};
         `KRC_ADDR_REV_HI: return otp_revision[15:8];
         `KRC_ADDR_REV_LO: return otp_revision[7:0];
         default: return `KRC_ZERO8;
      endcase
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(negedge mclk);
      if (w && a == `KRC_ADDR_SCNT && d[`KRC_SCNT_CLR_BIT] && permit)
      begin
         cnt = 0;
         permit = 0;
      end
      if (!w)
         chk(reg_rdata_q, model(a));
      else if (a >= `KRC_ADDR_SOFT && a <= `KRC_ADDR_FULL)
         cmd[a - `KRC_ADDR_SOFT] = d;
   endtask
   task automatic wait_up();
      lo = 0;
      while (system_reset_out_q !== 1'b1 && lo < 500)
      begin
         @(negedge mclk);
         lo++;
      end
      chk({7'h00, system_reset_out_q}, 8'h01);
      cnt = (cnt < 127) ? cnt + 1 : 127;
      repeat (2) @(negedge mclk);
   endtask
   task automatic go(input int c);
      logic [7:0] k;
      logic [7:0] v;
      k = rnd();
      @(posedge mclk);
      unlock_key <= k;
      case (c)
         0: v = ~k;
         1: v = {k[3:0], k[7:4]};
         default: for (int b = 0; b < 8; b++) v[b] = k[7 - b];
      endcase
      acc(1'b1, `KRC_ADDR_SOFT + 10'(c), v);
      chk({7'h00, system_reset_out_q}, 8'h00);
      chk({5'h00, always_on_regulator_en_q, rails_down_req_q, engine_off_only_shutdown_q},
         8'h04 + 8'(c) + 8'(c > 0));
      if (c == 2)
      begin
         cmd = '{default: 8'h00};
         permit = 1;
      end
      wait_up();
      if (c == 0)
         chk(8'(lo >= `KRC_PULSE_CYC && lo <= `KRC_PULSE_CYC + 2), 8'h01);
   endtask
   task automatic results();
      $display("checks %0d, mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      #1_000_000;
      mismatches++;
      results();
   end
   initial
   begin
      {reset_n, reg_wr, reg_rd, shadow_wr_req, fuse_busy, fuse_crc_fail} = 6'h00;
      seed = 32'h0000_be00;
      {mismatches, checks, cnt, permit} = {32'd0, 32'd0, 32'd0, 32'd1};
      {reg_addr, reg_wdata, dly} = {10'h000, 8'h00, 8'h02};
      unlock_key = rnd();
      otp_revision = {rnd(), rnd()};
      cmd = '{default: 8'h00};
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      wait_up();
      for (int i = 0; i < 8; i++)
      begin
         @(posedge mclk);
         {fuse_busy, fuse_crc_fail, shadow_wr_req} <= 3'(rnd());
         acc(1'b0, addrs[i], 8'h00);
         chk({7'h00, shadow_wr_en_q}, {7'h00, shadow_wr_req & ~fuse_busy});
      end
      $display("register read test done");
      acc(1'b1, `KRC_ADDR_SOFT, ~unlock_key ^ 8'h5a);
      chk({7'h00, system_reset_out_q}, 8'h01);
      go(0);
      acc(1'b1, `KRC_ADDR_SOFT, ~unlock_key);
      acc(1'b1, `KRC_ADDR_SOFT, ~unlock_key);
      wait_up();
      acc(1'b0, `KRC_ADDR_SCNT, 8'h00);
      $display("soft reset test done");
      acc(1'b1, `KRC_ADDR_SCNT, 8'h7f);
      acc(1'b1, `KRC_ADDR_SCNT, 8'h80);
      acc(1'b0, `KRC_ADDR_SCNT, 8'h00);
      go(0);
      acc(1'b1, `KRC_ADDR_SCNT, 8'h80);
      acc(1'b0, `KRC_ADDR_SCNT, 8'h00);
      $display("counter clear test done");
      for (int i = 1; i < 5; i++)
      begin
         dly = 8'(i * 20 - 18);
         go(1 + i % 2);
         acc(1'b0, `KRC_ADDR_SOFT + 10'(1 + i % 2), 8'h00);
         acc(1'b0, `KRC_ADDR_SCNT, 8'h00);
      end
      acc(1'b1, `KRC_ADDR_SCNT, 8'h80);
      acc(1'b0, `KRC_ADDR_SCNT, 8'h00);
      $display("hard and full restart test done");
      for (int i = 0; i < 128; i++)
         go(0);
      acc(1'b0, `KRC_ADDR_SCNT, 8'h00);
      $display("saturation test done");
      results();
   end
endmodule // testbench
`default_nettype wire
